// file: design/wdg_period_rom.sv
// registered lookup of period length in quarter-second ticks
`timescale 1ns/100ps
`default_nettype none
`include "wdg_cfg.svh"
module wdg_period_rom (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // lookup
  input wire logic [`WDG_SEL_W-1:0] sel,
  output logic [`WDG_CNT_W:0] ticks
);
  // eight codes from 1 tick (0.25 s) up to 1024 ticks (256 s)
  function automatic logic [`WDG_CNT_W:0] period_ticks(input logic [`WDG_SEL_W-1:0] code);
    case (code)
      3'h0: period_ticks = `WDG_PERIOD_0;
      3'h1: period_ticks = `WDG_PERIOD_1;
      3'h2: period_ticks = `WDG_PERIOD_2;
      3'h3: period_ticks = `WDG_PERIOD_3;
      3'h4: period_ticks = `WDG_PERIOD_4;
      3'h5: period_ticks = `WDG_PERIOD_5;
      3'h6: period_ticks = `WDG_PERIOD_6;
      default: period_ticks = `WDG_PERIOD_7;
    endcase
  endfunction
  wire logic [`WDG_CNT_W:0] next_ticks;
  assign next_ticks = period_ticks(sel);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ticks <= `WDG_PERIOD_0;
    else ticks <= next_ticks;
  end
endmodule // wdg_period_rom
`default_nettype wire

// file: design/wdg_two_stage.sv
// two-stage watchdog with reset-cause flag and board reset combiner
// Behaviour
// - eight periods are offered, from 0.25 s up to 256 s.
// - with stage one enabled, expiry raises the NMI before the reset stage.
// - a missed strobe yields NMI, reset or both per configuration.
// - a watchdog-caused reset sets a readable reset-cause flag.
// - power-up clears the cause flag and all watchdog state.
// - warm resets, including the watchdog's own, keep the cause flag.
// - push-button, backplane and watchdog each reset the system.
// - first- and second-stage timeouts are separate event pulses.
`timescale 1ns/100ps
`default_nettype none
`include "wdg_cfg.svh"
module wdg_two_stage (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic rst_b,
  // software control
  input wire logic wdgEnable,
  input wire logic nmiEnable,
  input wire logic resetEnable,
  input wire logic [`WDG_SEL_W-1:0] periodSel,
  input wire logic strobe,
  input wire logic causeClear,
  // board reset requests
  input wire logic pushButtonReset,
  input wire logic backplaneReset,
  // outputs
  output logic nmi,
  output logic first_stage_timeout_event,
  output logic second_stage_timeout_event,
  output logic wdgResetCause,
  output logic systemReset
);
  // ----------------------------------------
  // timebase and period
  // ----------------------------------------
  logic [23:0] preCnt;
  logic [`WDG_CNT_W:0] tickCnt;
  logic [`WDG_CNT_W:0] periodTicks;
  logic [7:0] rstCnt;
  wdg_pkg::wdg_state_type state;
  wdg_pkg::wdg_state_type next_state;
  wire logic warm;
  wire logic tick;
  wire logic expired;
  wire logic wdgReset;
  wire logic boardReq;
  wire logic enterReset;
  wire logic restartCount;
  wire logic [23:0] next_preCnt;
  wire logic [`WDG_CNT_W:0] next_tickCnt;
  wire logic [7:0] next_rstCnt;
  wire logic next_nmi;
  wire logic next_firstEvent;
  wire logic next_secondEvent;
  wire logic next_cause;
  wire logic next_systemReset;
  // period end test: true on the tick that completes the period
  function automatic logic last_tick(input logic [`WDG_CNT_W:0] cnt,
      input logic [`WDG_CNT_W:0] limit);
    last_tick = (cnt + 11'h001 >= limit);
  endfunction
  assign tick = (preCnt == 24'(`WDG_TICK_CYCLES - 1));
  assign expired = tick && last_tick(tickCnt, periodTicks);
  wdg_period_rom periodRom (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sel(periodSel),
    .ticks(periodTicks)
  );
  // watchdog state is held in warm reset too, so its reset pulse completes
  assign warm = pushButtonReset || backplaneReset;
  // ----------------------------------------
  // stage sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      wdg_pkg::WDG_IDLE: begin
        if (wdgEnable && expired) begin
          if (nmiEnable) next_state = wdg_pkg::WDG_SECOND;
          else if (resetEnable) next_state = wdg_pkg::WDG_RESET;
        end
      end
      wdg_pkg::WDG_SECOND: begin
        if (strobe || !wdgEnable) next_state = wdg_pkg::WDG_IDLE;
        else if (expired && resetEnable) next_state = wdg_pkg::WDG_RESET;
      end
      wdg_pkg::WDG_RESET: begin
        if (rstCnt == 8'h00) next_state = wdg_pkg::WDG_IDLE;
      end
      default: next_state = wdg_pkg::WDG_IDLE;
    endcase
  end
  // ----------------------------------------
  // decoded next values
  // ----------------------------------------
  assign wdgReset = (state == wdg_pkg::WDG_RESET);
  assign enterReset = (next_state == wdg_pkg::WDG_RESET) && !wdgReset;
  assign boardReq = warm || wdgReset;
  // strobe, disable, expiry or warm reset restart the period count
  assign restartCount = strobe || !wdgEnable || expired || warm;
  assign next_preCnt = (tick || strobe || warm) ? 24'h000000 : preCnt + 24'h000001;
  assign next_tickCnt = restartCount ? 11'h000
    : (tick ? tickCnt + 11'h001 : tickCnt);
  // pulse length counted here so a strobe cannot cut the reset short
  assign next_rstCnt = enterReset ? `WDG_RST_PULSE
    : ((rstCnt != 8'h00) ? rstCnt - 8'h01 : rstCnt);
  assign next_nmi = (next_state == wdg_pkg::WDG_SECOND);
  assign next_firstEvent = (state == wdg_pkg::WDG_IDLE) && wdgEnable
    && expired && nmiEnable;
  assign next_secondEvent = enterReset;
  // set beats clear; warm reset leaves the flag alone
  assign next_cause = (next_state == wdg_pkg::WDG_RESET)
    || (wdgResetCause && !causeClear);
  assign next_systemReset = boardReq || (next_state == wdg_pkg::WDG_RESET);
  // ----------------------------------------
  // stage register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= wdg_pkg::WDG_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // ----------------------------------------
  // quarter-second prescaler
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      preCnt <= 24'h000000;
    end else begin
      preCnt <= next_preCnt;
    end
  end
  // ----------------------------------------
  // period tick counter
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt <= 11'h000;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end
  // ----------------------------------------
  // reset pulse counter
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstCnt <= 8'h00;
    end else begin
      rstCnt <= next_rstCnt;
    end
  end
  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi <= 1'b0;
    end else begin
      nmi <= next_nmi;
    end
  end
  // ----------------------------------------
  // timeout event pulses
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_stage_timeout_event <= 1'b0;
    end else begin
      first_stage_timeout_event <= next_firstEvent;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_stage_timeout_event <= 1'b0;
    end else begin
      second_stage_timeout_event <= next_secondEvent;
    end
  end
  // ----------------------------------------
  // reset-cause flag
  // ----------------------------------------
  // only power-on or causeClear clears it; warm requests never reach this flop
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdgResetCause <= 1'b0;
    end else begin
      wdgResetCause <= next_cause;
    end
  end
  // ----------------------------------------
  // board reset combiner
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      systemReset <= 1'b0;
    end else begin
      systemReset <= next_systemReset;
    end
  end
endmodule // wdg_two_stage
`default_nettype wire

// file: include/wdg_cfg.svh
// timing and reset constants of the two-stage watchdog
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH
`define WDG_CLK_HZ 10000000
`define WDG_TICK_US 250000
`define WDG_TICK_CYCLES ((`WDG_CLK_HZ / 1000) * (`WDG_TICK_US / 1000))
`define WDG_SEL_W 3
`define WDG_CNT_W 10
`define WDG_SEL_RESET 3'h0
`define WDG_RST_PULSE 8'h10
`define WDG_PERIOD_0 11'h001
`define WDG_PERIOD_1 11'h002
`define WDG_PERIOD_2 11'h004
`define WDG_PERIOD_3 11'h008
`define WDG_PERIOD_4 11'h020
`define WDG_PERIOD_5 11'h080
`define WDG_PERIOD_6 11'h200
`define WDG_PERIOD_7 11'h400
`endif

// file: include/wdg_pkg.sv
// types of the two-stage watchdog
package wdg_pkg;
  typedef enum logic [1:0] {
    WDG_IDLE,
    WDG_FIRST,
    WDG_SECOND,
    WDG_RESET
  } wdg_state_type;
endpackage

// file: verification/wdg_asserts.sv
// port assertions for the two-stage watchdog
`timescale 1ns/100ps
`default_nettype none
module wdg_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // watched ports
  input wire logic pushButtonReset,
  input wire logic backplaneReset,
  input wire logic causeClear,
  input wire logic nmi,
  input wire logic first_stage_timeout_event,
  input wire logic second_stage_timeout_event,
  input wire logic wdgResetCause,
  input wire logic systemReset
);
  wire ev1 = first_stage_timeout_event;
  wire ev2 = second_stage_timeout_event;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  warm_req_a:
    assert property ((pushButtonReset || backplaneReset) |=> systemReset) else $error("no rst");
  ev1_pulse_a: assert property (ev1 |=> !ev1) else $error("ev1 wide");
  ev2_pulse_a: assert property (ev2 |=> !ev2) else $error("ev2 wide");
  stage_excl_a: assert property (!(ev1 && ev2)) else $error("both events");
  nmi_first_a: assert property ($rose(nmi) |-> ev1) else $error("nmi early");
  cause_set_a: assert property ($rose(wdgResetCause) |-> ev2) else $error("cause set");
  cause_keep_a:
    assert property ($fell(wdgResetCause) |-> $past(causeClear)) else $error("cause lost");
  wd_pulse_a:
    assert property (ev2 |-> wdgResetCause ##0 systemReset [*8]) else $error("short rst");
  cover property (ev1);
  cover property (ev2);
  cover property (pushButtonReset ##1 systemReset);
endmodule // wdg_asserts
bind wdg_two_stage wdg_asserts u_chk (.core_clk, .rst_b, .pushButtonReset, .backplaneReset,
  .causeClear, .nmi, .first_stage_timeout_event, .second_stage_timeout_event, .wdgResetCause,
  .systemReset);
`default_nettype wire

// file: verification/wdg_two_stage_tb_top.sv
// self-checking bench for the two-stage watchdog
`timescale 1ns/100ps
`default_nettype none
`include "wdg_cfg.svh"
module wdg_two_stage_tb_top;
  logic core_clk = 1'h0, rst_b = 1'h0, wdgEnable = 1'h0, nmiEnable = 1'h0, resetEnable = 1'h0;
  logic strobe = 1'h0, causeClear = 1'h0, pushButtonReset = 1'h0, backplaneReset = 1'h0;
  logic [`WDG_SEL_W-1:0] periodSel = 3'h0;
  logic nmi, ev1, ev2, wdgResetCause, systemReset;
  logic [4:0] expQ[$];
  logic [31:0] rnd = 32'hDEB548CC;
  int mismatches = 0, n_checks = 0;
  always #50 core_clk = ~core_clk;
  wdg_two_stage i_dut (.core_clk, .rst_b, .wdgEnable, .nmiEnable, .resetEnable, .periodSel,
    .strobe, .causeClear, .pushButtonReset, .backplaneReset, .nmi,
    .first_stage_timeout_event(ev1), .second_stage_timeout_event(ev2), .wdgResetCause,
    .systemReset);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // notes are compared at the falling edge, once registered outputs settle
  always @(negedge core_clk) if (expQ.size() != 0) begin : mon
    logic [4:0] e;
    e = expQ.pop_front();
    n_checks++;
    if ({nmi, ev1, ev2, wdgResetCause, systemReset} !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, {nmi, ev1, ev2, wdgResetCause, systemReset}, e);
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic randomize_ctl;
    rnd = lfsr(rnd);
    wdgEnable <= rnd[0];
    nmiEnable <= rnd[1];
    resetEnable <= rnd[2];
    periodSel <= rnd[5:3];
    strobe <= rnd[6];
    causeClear <= rnd[7];
  endtask
  initial begin
    @(posedge core_clk) expQ.push_back(5'h00);
    repeat (3) @(posedge core_clk);
    rst_b <= 1'h1;
    // short period ticks are millions of cycles, so no expiry is expected here
    repeat (60) @(posedge core_clk) begin
      randomize_ctl();
      expQ.push_back(5'h00);
    end
    $display("strobe test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) randomize_ctl();
      pushButtonReset <= rnd[8];
      backplaneReset <= !rnd[8];
      @(posedge core_clk) expQ.push_back(5'h01);
      @(posedge core_clk) {pushButtonReset, backplaneReset} <= 2'h0;
      @(posedge core_clk);
      @(posedge core_clk) expQ.push_back(5'h00);
      repeat (20) @(posedge core_clk);
    end
    $display("warm reset test done");
    @(posedge core_clk) rst_b <= 1'h0;
    pushButtonReset <= 1'h1;
    @(posedge core_clk) expQ.push_back(5'h00);
    @(posedge core_clk) pushButtonReset <= 1'h0;
    @(posedge core_clk) rst_b <= 1'h1;
    repeat (2) @(posedge core_clk) expQ.push_back(5'h00);
    repeat (20) @(posedge core_clk);
    $display("power-on test done");
    tally_and_finish();
  end
  initial begin
    #(2000 * 100);
    mismatches++;
    tally_and_finish();
  end
endmodule // wdg_two_stage_tb_top
`default_nettype wire
